// ==== src/ddi_pkg.sv ====
package ddi_pkg;
    localparam int ADDR_W = 13;
    localparam int BA_W   = 2;
    // Command encoding {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP  = 4'h7;
    localparam logic [3:0] CMD_MRS  = 4'h0;
    localparam logic [3:0] CMD_PRE  = 4'h2;
    localparam logic [3:0] CMD_REF  = 4'h1;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_DESL = 4'h8;
    // Mode register fields
    localparam int BL_LSB  = 0;
    localparam int BT_BIT  = 3;
    localparam int CL_LSB  = 4;
    localparam int TM_BIT  = 7;
    localparam int DLL_BIT = 8;
    localparam int AP_BIT  = 10;
    localparam int DLL_EN_BIT = 0;
    // Burst length codes
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    // CAS latency codes; value in half cycles
    localparam logic [2:0] CL_CODE_2  = 3'h2;
    localparam logic [2:0] CL_CODE_3  = 3'h3;
    localparam logic [2:0] CL_CODE_25 = 3'h6;
    localparam logic [3:0] CL_HALF_2  = 4'h4;
    localparam logic [3:0] CL_HALF_3  = 4'h6;
    localparam logic [3:0] CL_HALF_25 = 4'h5;
    // Timing
    localparam int CLK_MHZ       = 20;
    localparam int T_STABLE_US   = 200;
    localparam int STABLE_CYC    = T_STABLE_US * CLK_MHZ;
    localparam int DLL_LOCK_CYC  = 200;
    localparam int MRD_CYC       = 2;
    localparam int T_RP_NS       = 20;
    localparam int CLK_PER_NS    = 50;
    localparam int RP_CYC_RAW    = (T_RP_NS + CLK_PER_NS - 1) / CLK_PER_NS;
    localparam int RP_CYC        = (RP_CYC_RAW < 1) ? 1 : RP_CYC_RAW;
    localparam int MIN_REFRESH   = 2;
    localparam int T_RFC_CYC     = 2;
    // Control port register offsets and status bits
    localparam int         REG_AW    = 2;
    localparam logic [1:0] REG_MODE  = 2'h0;
    localparam logic [1:0] REG_STAT  = 2'h1;
    localparam int         STAT_DONE = 0;
    localparam int         STAT_BUSY = 1;
    localparam int         STAT_RDOK = 2;
endpackage

// ==== src/ddi_if.sv ====
`timescale 1ns/10ps
interface ddi_if;
    import ddi_pkg::*;
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
    modport ctrl (output cke, output cs_n, output ras_n, output cas_n, output we_n,
                  output ba, output addr);
    modport mem  (input cke, input cs_n, input ras_n, input cas_n, input we_n,
                  input ba, input addr);
endinterface

// ==== src/ddi_burst_order.sv ====
`timescale 1ns/10ps
module ddi_burst_order
    import ddi_pkg::*;
(
    input  wire logic       interleave,
    input  wire logic [2:0] len_mask,
    input  wire logic [2:0] start_col,
    input  wire logic [2:0] beat,
    output logic      [2:0] col
);
    logic [2:0] seq_col;
    logic [2:0] ilv_col;
    assign seq_col = (start_col & ~len_mask) | ((start_col + beat) & len_mask);
    assign ilv_col = (start_col & ~len_mask) | ((start_col ^ beat) & len_mask);
    assign col = interleave ? ilv_col : seq_col;
endmodule

// ==== src/ddi_mem.sv ====
`timescale 1ns/10ps
// Behaviour
// - Controller holds clock enable low at power-up
// - Clock runs stably 200 us first
// - Then NOP with clock enable raised
// - Precharge all banks before extended mode set
// - Extended set: A0 low, BA0 high, rest low
// - Mode set A8 high resets DLL, wait 200
// - Second precharge all; order with DLL reset free
// - At least two auto-refreshes after that
// - Final mode set with A8 low
// - Mode register undefined until written after extended
// - Mode set: select, RAS, CAS, WE, BA0 low
// - Mode set only when idle, clock enable high
// - Capture A0 to A12 on mode set
// - Two cycles after mode write before next
// - Decode burst length, type, CAS latency
// - Test mode bit A7 kept low
// - A8 high requests DLL reset
// - Sequential order wraps within burst block
// - Interleave order XORs start with beat
// - Row precharge time before mode set
// - 200 cycles after DLL enable before read
module ddi_mem
    import ddi_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    ddi_if.mem              link,
    input  wire logic [2:0] burst_start,
    input  wire logic [2:0] burst_beat,
    output logic            mode_valid,
    output logic            ext_valid,
    output logic [ADDR_W-1:0] mode_reg,
    output logic [ADDR_W-1:0] ext_reg,
    output logic [3:0]      burst_len,
    output logic            burst_interleave,
    output logic [3:0]      cas_half,
    output logic            mode_reserved,
    output logic            test_mode,
    output logic            dll_enabled,
    output logic            dll_reset_req,
    output logic            dll_locked,
    output logic [2:0]      burst_col
);
    logic [3:0] cmd;
    logic       is_mrs;
    logic       is_emrs;
    logic       cke_q;
    logic [7:0] lock_cnt;
    logic [3:0] next_len;
    logic [2:0] next_mask;
    logic [3:0] next_cl;
    logic       next_res;
    logic [2:0] len_mask;
    logic [2:0] col;

    assign cmd     = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
    assign is_mrs  = cke_q && cmd == CMD_MRS && !link.ba[0];
    assign is_emrs = cke_q && cmd == CMD_MRS && link.ba[0];

    always_ff @(posedge clk) begin
        if (!rst_n) cke_q <= 1'b0;
        else cke_q <= link.cke;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_reg   <= '0;
            ext_valid <= 1'b0;
        end else if (is_emrs) begin
            ext_reg   <= link.addr;
            ext_valid <= 1'b1;
        end
    end

    always_comb begin
        next_len  = 4'h0;
        next_mask = 3'h0;
        next_res  = 1'b0;
        case (link.addr[BL_LSB+:3])
            BL_CODE_2: begin
                next_len  = 4'h2;
                next_mask = 3'h1;
            end
            BL_CODE_4: begin
                next_len  = 4'h4;
                next_mask = 3'h3;
            end
            BL_CODE_8: begin
                next_len  = 4'h8;
                next_mask = 3'h7;
            end
            default:   next_res = 1'b1;
        endcase
        next_cl = 4'h0;
        case (link.addr[CL_LSB+:3])
            CL_CODE_2:  next_cl = CL_HALF_2;
            CL_CODE_25: next_cl = CL_HALF_25;
            CL_CODE_3:  next_cl = CL_HALF_3;
            default:    next_res = 1'b1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_reg         <= '0;
            mode_valid       <= 1'b0;
            burst_len        <= 4'h0;
            len_mask         <= 3'h0;
            burst_interleave <= 1'b0;
            cas_half         <= 4'h0;
            mode_reserved    <= 1'b0;
            test_mode        <= 1'b0;
            dll_reset_req    <= 1'b0;
        end else if (is_mrs) begin
            mode_reg         <= link.addr;
            mode_valid       <= ext_valid;
            burst_len        <= next_len;
            len_mask         <= next_mask;
            burst_interleave <= link.addr[BT_BIT];
            cas_half         <= next_cl;
            mode_reserved    <= next_res;
            test_mode        <= link.addr[TM_BIT];
            dll_reset_req    <= link.addr[DLL_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dll_enabled <= 1'b0;
        end else if (is_emrs) begin
            dll_enabled <= !link.addr[DLL_EN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lock_cnt   <= 8'h00;
            dll_locked <= 1'b0;
        end else if ((is_mrs && link.addr[DLL_BIT]) || (is_emrs && !link.addr[DLL_EN_BIT])) begin
            lock_cnt   <= 8'h00;
            dll_locked <= 1'b0;
        end else if (dll_enabled && !dll_locked) begin
            if (lock_cnt == 8'(DLL_LOCK_CYC - 1)) dll_locked <= 1'b1;
            else lock_cnt <= lock_cnt + 8'h01;
        end
    end

    ddi_burst_order u_order (
        .interleave (burst_interleave),
        .len_mask   (len_mask),
        .start_col  (burst_start),
        .beat       (burst_beat),
        .col        (col)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) burst_col <= 3'h0;
        else burst_col <= col;
    end
endmodule

// ==== src/ddi_ctrl.sv ====
`timescale 1ns/10ps
module ddi_ctrl
    import ddi_pkg::*;
#(
    parameter int STABLE_CYCLES = STABLE_CYC,
    parameter int REFRESHES     = MIN_REFRESH
)(
    input  wire logic              clk,
    input  wire logic              rst_n,
    ddi_if.ctrl                    link,
    input  wire logic [REG_AW-1:0] reg_addr,
    input  wire logic [ADDR_W-1:0] reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [ADDR_W-1:0] reg_rdata,
    output logic                   init_done,
    output logic                   busy,
    output logic                   read_ok
);
    typedef enum logic [3:0] {
        ST_PWR  = 4'h0, ST_NOP  = 4'h1, ST_PRE1 = 4'h3, ST_EMRS = 4'h2,
        ST_DLLR = 4'h6, ST_PRE2 = 4'h7, ST_REF  = 4'h5, ST_MRS  = 4'h4,
        ST_IDLE = 4'hc, ST_WAIT = 4'hd, ST_UMRS = 4'hf
    } ddi_state_t;
    ddi_state_t state;
    ddi_state_t after;
    logic [15:0] cnt;
    logic [7:0]  dll_cnt;
    logic [3:0]  ref_cnt;
    logic        pend;
    logic [ADDR_W-1:0] pend_val;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend     <= 1'b0;
            pend_val <= '0;
        end else if (reg_write && reg_addr == REG_MODE) begin
            pend     <= 1'b1;
            pend_val <= reg_wdata & ~(ADDR_W'(1) << TM_BIT);
        end else if (state == ST_UMRS) begin
            pend <= 1'b0;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_read && reg_addr == REG_MODE) begin
            reg_rdata <= pend_val;
        end else if (reg_read && reg_addr == REG_STAT) begin
            reg_rdata            <= '0;
            reg_rdata[STAT_DONE] <= init_done;
            reg_rdata[STAT_BUSY] <= busy;
            reg_rdata[STAT_RDOK] <= read_ok;
        end else begin
            reg_rdata <= '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state     <= ST_PWR;
            after     <= ST_PWR;
            cnt       <= 16'h0000;
            ref_cnt   <= 4'h0;
            link.cke  <= 1'b0;
            link.cs_n <= 1'b1;
            link.ras_n <= 1'b1;
            link.cas_n <= 1'b1;
            link.we_n <= 1'b1;
            link.ba   <= '0;
            link.addr <= '0;
            init_done <= 1'b0;
            busy      <= 1'b1;
        end else begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
            link.ba   <= '0;
            link.addr <= '0;
            case (state)
                ST_PWR: begin
                    if (cnt == 16'(STABLE_CYCLES - 1)) begin
                        cnt      <= 16'h0000;
                        link.cke <= 1'b1;
                        state    <= ST_NOP;
                    end else cnt <= cnt + 16'h0001;
                end
                ST_NOP: state <= ST_PRE1;
                ST_PRE1, ST_PRE2: begin
                    {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_PRE;
                    link.addr[AP_BIT] <= 1'b1;
                    cnt   <= 16'(RP_CYC);
                    after <= (state == ST_PRE1) ? ST_EMRS : ST_REF;
                    state <= ST_WAIT;
                end
                ST_EMRS: begin
                    {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_MRS;
                    link.ba[0] <= 1'b1;
                    cnt   <= 16'(MRD_CYC);
                    after <= ST_DLLR;
                    state <= ST_WAIT;
                end
                ST_DLLR: begin
                    {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_MRS;
                    link.addr <= pend_val | (ADDR_W'(1) << DLL_BIT);
                    cnt   <= 16'(MRD_CYC);
                    after <= ST_PRE2;
                    state <= ST_WAIT;
                end
                ST_REF: begin
                    {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_REF;
                    ref_cnt <= ref_cnt + 4'h1;
                    cnt   <= 16'(T_RFC_CYC);
                    after <= (ref_cnt == 4'(REFRESHES - 1)) ? ST_MRS : ST_REF;
                    state <= ST_WAIT;
                end
                ST_MRS: begin
                    {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_MRS;
                    link.addr <= pend_val & ~(ADDR_W'(1) << DLL_BIT);
                    cnt   <= 16'(MRD_CYC);
                    after <= ST_IDLE;
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (cnt <= 16'h0001) state <= after;
                    else cnt <= cnt - 16'h0001;
                end
                ST_IDLE: begin
                    init_done <= 1'b1;
                    busy      <= pend;
                    if (pend) state <= ST_UMRS;
                end
                ST_UMRS: begin
                    {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_MRS;
                    link.addr <= pend_val;
                    cnt   <= 16'(MRD_CYC);
                    after <= ST_IDLE;
                    busy  <= 1'b1;
                    state <= ST_WAIT;
                end
                default: state <= ST_PWR;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dll_cnt <= 8'h00;
            read_ok <= 1'b0;
        end else if (state == ST_EMRS || state == ST_DLLR) begin
            dll_cnt <= 8'h00;
            read_ok <= 1'b0;
        end else if (!read_ok && init_done) begin
            if (dll_cnt >= 8'(DLL_LOCK_CYC - 1)) read_ok <= 1'b1;
            else dll_cnt <= dll_cnt + 8'h01;
        end else if (!read_ok) begin
            if (dll_cnt < 8'(DLL_LOCK_CYC - 1)) dll_cnt <= dll_cnt + 8'h01;
        end
    end
endmodule

// ==== testbench/ddi_properties.sv ====
`timescale 1ns/10ps
module ddi_properties
    import ddi_pkg::*;
#(
    parameter int STABLE_CYCLES = STABLE_CYC,
    parameter int REFRESHES     = MIN_REFRESH
)(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              cke,
    input wire logic              cs_n,
    input wire logic              ras_n,
    input wire logic              cas_n,
    input wire logic              we_n,
    input wire logic [BA_W-1:0]   ba,
    input wire logic [ADDR_W-1:0] addr
);
    logic [3:0]  cmd;
    logic [15:0] low_cnt;
    logic [2:0]  ref_cnt;
    logic        emrs_seen;
    logic        dllr_seen;
    logic [1:0]  pre_cnt;
    logic [3:0]  pre_gap;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    // Cycles since the last precharge, counting its own
    always_ff @(posedge clk) begin
        if (!rst_n)
            pre_gap <= 4'hF;
        else if (cmd == CMD_PRE)
            pre_gap <= 4'h1;
        else if (pre_gap != 4'hF)
            pre_gap <= pre_gap + 4'h1;
    end
    // Cycles spent with clock enable low
    always_ff @(posedge clk) begin
        if (!rst_n)
            low_cnt <= '0;
        else if (!cke && low_cnt != 16'hFFFF)
            low_cnt <= low_cnt + 16'h0001;
    end
    // Init steps seen so far
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ref_cnt   <= '0;
            emrs_seen <= 1'b0;
            dllr_seen <= 1'b0;
            pre_cnt   <= '0;
        end else begin
            if (cmd == CMD_PRE && pre_cnt != 2'h3)
                pre_cnt <= pre_cnt + 2'h1;
            if (cmd == CMD_REF && ref_cnt != 3'h7)
                ref_cnt <= ref_cnt + 3'h1;
            if (cmd == CMD_MRS && ba[0])
                emrs_seen <= 1'b1;
            if (cmd == CMD_MRS && !ba[0] && addr[DLL_BIT])
                dllr_seen <= 1'b1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence pwr_up_s;
        cmd == CMD_NOP ##1 cmd == CMD_NOP ##1 (cmd == CMD_PRE && addr[AP_BIT]);
    endsequence
    sequence mrs_s;
        cmd == CMD_MRS;
    endsequence
    sequence quiet_s;
        cmd == CMD_NOP || cs_n;
    endsequence
    cke_reset_a: assert property (disable iff (1'b0) !rst_n |=> !cke)
        else $error("clock enable high after reset");
    stable_wait_a: assert property ($rose(cke) |-> low_cnt >= STABLE_CYCLES)
        else $error("clock enable raised too early");
    init_start_a: assert property ($rose(cke) |-> pwr_up_s)
        else $error("bad start of init");
    mrs_cke_a: assert property (mrs_s |-> cke && $past(cke))
        else $error("mode set with clock enable low");
    mrs_gap_a: assert property (mrs_s |=> quiet_s ##1 quiet_s)
        else $error("command within two cycles of mode set");
    ref_order_a: assert property (cmd == CMD_REF |-> pre_cnt >= 2'h2 && emrs_seen)
        else $error("refresh before second precharge");
    pre_gap_a: assert property (mrs_s |-> pre_gap >= RP_CYC)
        else $error("mode set too soon after precharge");
    emrs_code_a: assert property (cmd == CMD_MRS && ba[0] |-> addr == '0 && !ba[1])
        else $error("bad extended mode code");
    test_bit_a: assert property (cmd == CMD_MRS && !ba[0] |-> !addr[TM_BIT] && emrs_seen)
        else $error("test bit set or mode set before extended");
    pre_all_a: assert property (cmd == CMD_PRE |-> addr[AP_BIT])
        else $error("precharge not to all banks");
    final_mrs_a: assert property (cmd == CMD_MRS && !ba[0] && !addr[DLL_BIT]
        |-> dllr_seen && ref_cnt >= REFRESHES)
        else $error("final mode set out of order");
endmodule

// ==== testbench/dram_init_mode_register_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value at %0t: %h expected %h", $time, a, b); end end
`define WAIT(s, v, n) begin for (int k = 0; k < n && (s) !== v; k++) tick(1); `CHK(s, v) end
module dram_init_mode_register_tb_top
    import ddi_pkg::*;
;
    localparam int STAB = 20;
    logic              clk;
    logic              rst_n;
    logic [REG_AW-1:0] reg_addr;
    logic [ADDR_W-1:0] reg_wdata;
    logic              reg_write;
    logic              reg_read;
    logic [ADDR_W-1:0] reg_rdata;
    logic [2:0]        burst_start;
    logic [2:0]        burst_beat;
    logic [2:0]        burst_col;
    logic              init_done, busy, read_ok, mode_valid, ext_valid, burst_interleave;
    logic              mode_reserved, test_mode, dll_enabled, dll_reset_req, dll_locked;
    logic [ADDR_W-1:0] mode_reg, ext_reg;
    logic [3:0]        burst_len, cas_half;
    int                err_count = 0;
    int                tests_run = 0;
    ddi_if link_if ();
    ddi_ctrl #(.STABLE_CYCLES(STAB), .REFRESHES(MIN_REFRESH)) ddi_ctrl_inst (.clk, .rst_n,
        .link(link_if.ctrl), .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .init_done, .busy, .read_ok);
    ddi_mem ddi_mem_inst (.clk, .rst_n, .link(link_if.mem), .burst_start, .burst_beat,
        .mode_valid, .ext_valid, .mode_reg, .ext_reg, .burst_len, .burst_interleave,
        .cas_half, .mode_reserved, .test_mode, .dll_enabled, .dll_reset_req, .dll_locked,
        .burst_col);
    ddi_properties #(.STABLE_CYCLES(STAB), .REFRESHES(MIN_REFRESH)) ddi_properties_inst (
        .clk, .rst_n, .cke(link_if.cke), .cs_n(link_if.cs_n), .ras_n(link_if.ras_n),
        .cas_n(link_if.cas_n), .we_n(link_if.we_n), .ba(link_if.ba), .addr(link_if.addr));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic t_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        tick(9);
        `CHK(link_if.cke, 1'b0)
        `CHK(mode_valid, 1'b0)
        `CHK(ext_valid, 1'b0)
        @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic reg_rd(input logic [REG_AW-1:0] a, output logic [ADDR_W-1:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic t_init();
        logic [ADDR_W-1:0] rd;
        `WAIT(dll_reset_req, 1'b1, STAB + 100)
        `CHK(mode_valid, 1'b1)
        `CHK(ext_valid, 1'b1)
        `CHK(mode_reg[DLL_BIT], 1'b1)
        `CHK(init_done, 1'b0)
        `CHK(ext_reg, 13'h0000)
        `CHK(dll_enabled, 1'b1)
        `WAIT(init_done, 1'b1, 100)
        tick(1);
        `CHK(mode_valid, 1'b1)
        `CHK(dll_reset_req, 1'b0)
        `CHK(read_ok, 1'b0)
        reg_rd(REG_STAT, rd);
        `CHK(rd[STAT_DONE], 1'b1)
        `CHK(rd[STAT_BUSY], 1'b0)
        `CHK(rd[STAT_RDOK], 1'b0)
        `WAIT(read_ok, 1'b1, DLL_LOCK_CYC + 20)
        reg_rd(REG_STAT, rd);
        `CHK(rd[STAT_RDOK], 1'b1)
        tick(2);
        `CHK(dll_locked, 1'b1)
    endtask
    task automatic set_mode(input logic [ADDR_W-1:0] m);
        @(posedge clk);
        reg_addr  <= REG_MODE;
        reg_wdata <= m;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        tick(3);
        `WAIT(busy, 1'b0, 50)
        tick(3);
    endtask
    task automatic t_modes();
        logic [ADDR_W-1:0] m;
        logic [3:0]        bl;
        logic [3:0]        cl;
        logic [ADDR_W-1:0] rd;
        for (int i = 0; i < 8; i++) begin
            m = ADDR_W'(i * 16 + (i % 2) * 8 + i);
            bl = (i == 1) ? 4'h2 : (i == 2) ? 4'h4 : (i == 3) ? 4'h8 : 4'h0;
            cl = (i == 2) ? 4'h4 : (i == 3) ? 4'h6 : (i == 6) ? 4'h5 : 4'h0;
            set_mode(m | 13'h0080);
            `CHK(mode_reg, m)
            `CHK(test_mode, 1'b0)
            `CHK(burst_len, bl)
            `CHK(cas_half, cl)
            `CHK(burst_interleave, m[BT_BIT])
            `CHK(mode_reserved, bl == 4'h0 || cl == 4'h0)
            reg_rd(REG_MODE, rd);
            `CHK(rd, m)
        end
    endtask
    task automatic t_burst();
        int m;
        for (int b = 1; b < 4; b++) for (int t = 0; t < 2; t++) begin
            set_mode(ADDR_W'(32 + t * 8 + b));
            m = (1 << b) - 1;
            for (int s = 0; s < 8; s++) for (int k = 0; k <= m; k++) begin
                @(posedge clk);
                burst_start <= 3'(s);
                burst_beat  <= 3'(k);
                tick(2);
                if (t == 1) `CHK(burst_col, 3'(s ^ k))
                else `CHK(burst_col, 3'(s - s % (m + 1) + (s + k) % (m + 1)))
            end
        end
    endtask
    initial begin
        rst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        burst_start = '0;
        burst_beat = '0;
        t_reset();
        t_init();
        t_modes();
        t_burst();
        t_reset();
        t_init();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_sim();
    end
endmodule
